// >>> hw/ssc_pkg.sv
// Constants for the sample-sync, clamp and gain register bank.
// Assumes a single 50 MHz system clock and a plain strobe register port.
package ssc_pkg;
  localparam logic [7:0] ADDR_SETUP       = 8'h06;
  localparam logic [7:0] ADDR_OFF_RED     = 8'h20;
  localparam logic [7:0] ADDR_OFF_GREEN   = 8'h21;
  localparam logic [7:0] ADDR_OFF_BLUE    = 8'h22;
  localparam logic [7:0] ADDR_OFF_ALL     = 8'h23;
  localparam logic [7:0] ADDR_GLO_RED     = 8'h24;
  localparam logic [7:0] ADDR_GLO_GREEN   = 8'h25;
  localparam logic [7:0] ADDR_GLO_BLUE    = 8'h26;
  localparam logic [7:0] ADDR_GLO_ALL     = 8'h27;
  localparam logic [7:0] ADDR_GUP_RED     = 8'h28;
  localparam logic [7:0] ADDR_GUP_GREEN   = 8'h29;
  localparam logic [7:0] ADDR_GUP_BLUE    = 8'h2A;
  localparam logic [7:0] ADDR_GUP_ALL     = 8'h2B;
  localparam logic [7:0] ADDR_MODE        = 8'h30;
  localparam logic [7:0] ADDR_STATUS      = 8'h31;
  // Setup register fields.
  localparam int BIT_DET_EN   = 0;
  localparam int BIT_DLY_LO   = 1;
  localparam int BIT_POL      = 4;
  localparam int BIT_CLAMP_EN = 5;
  localparam int BIT_CLAMP_SEL = 6;
  localparam logic [7:0] SETUP_RST   = 8'h20;
  localparam logic [7:0] SETUP_MASK  = 8'h7F;
  localparam logic [7:0] OFFSET_RST  = 8'h80;
  localparam logic [7:0] GAIN_UP_RST = 8'h0C;
  localparam logic       GAIN_LO_RST = 1'b0;
  localparam logic [7:0] BCAST_RST   = 8'h00;
  // Mode register: bit 0 older timing mode, bits 2:1 reference sample timing.
  localparam int BIT_OLD_MODE = 0;
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] MODE_MASK   = 8'h07;
  localparam logic [7:0] DATA_ZERO   = 8'h00;
  localparam logic [2:0] DLY_ZERO    = 3'h0;
  localparam logic [2:0] DLY_ONE     = 3'h1;
endpackage

// >>> hw/ssc_regs.sv
// Register bank and sample-pulse timing for a three-channel digitiser front end.
// Assumes pins arrive asynchronously and software uses a one-cycle strobe port.
`timescale 1ns/1ps
// Functional notes
// - Detect enable is ignored unless older timing mode is selected.
// - Detect disabled: video sample pin passes straight to timing control.
// - Older mode with detect on: internal pulse replaces the raw pin.
// - Internal pulse is delayed by the delay field in master clock periods.
// - Delay and polarity only matter with older mode and detect on.
// - Polarity bit 0 detects falling edges, 1 detects rising edges.
// - Clamp enable resets to one and enables reset-level clamping.
// - Older mode clamps every pixel at the reference sample timing instant.
// - Control bit clear: clamp closes while reset sample pin is high.
// - Control bit set: clamp closes only while both sample pins high.
// - Clamp control bit is ignored in older timing mode.
// - Each channel holds an 8-bit offset code resetting to midscale.
// - Broadcast offset write overwrites red, green and blue offset codes.
// - Gain code is upper register bits eight to one plus low bit.
// - Broadcast low write overwrites all three gain low bits.
// - Broadcast upper write overwrites all three upper gain fields.
// - Gain upper registers reset to 0x0C; gain set by 9-bit code.
module ssc_regs
  import ssc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       video_sample_pin,
  input  wire logic       reset_sample_pin,
  input  wire logic       ref_sample_strobe,
  output logic            timing_sample,
  output logic            reset_level_clamp,
  output logic      [7:0] red_offset_code,
  output logic      [7:0] green_offset_code,
  output logic      [7:0] blue_offset_code,
  output logic      [8:0] red_gain_code,
  output logic      [8:0] green_gain_code,
  output logic      [8:0] blue_gain_code
);

  logic [7:0] setup_q;
  logic [7:0] mode_q;
  logic [7:0] off_q [3];
  logic [7:0] gup_q [3];
  logic       glo_q [3];
  logic [7:0] off_all_q;
  logic [7:0] gup_all_q;
  logic       glo_all_q;
  logic [1:0] vs_sync_q;
  logic [1:0] rs_sync_q;
  logic       vs_prev_q;
  logic [2:0] dly_cnt_q;
  logic       dly_busy_q;
  logic       pulse_q;
  logic       clamp_q;
  logic       vs_s;
  logic       rs_s;
  logic       older_mode;
  logic       detect_on;
  logic       edge_seen;

  // Write decoder helper: true when a write strobe hits the given address.
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // Setup and mode registers; reserved bits are forced low.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setup_q <= SETUP_RST;
      mode_q  <= MODE_RST;
    end else begin
      if (wr_hit(ADDR_SETUP)) begin
        setup_q <= reg_wdata & SETUP_MASK;
      end
      if (wr_hit(ADDR_MODE)) begin
        mode_q <= reg_wdata & MODE_MASK;
      end
    end
  end

  // Per-channel offset storage; the broadcast wins over a channel write since both cannot coincide.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        off_q[i] <= OFFSET_RST;
      end
      off_all_q <= BCAST_RST;
    end else if (wr_hit(ADDR_OFF_ALL)) begin
      off_all_q <= reg_wdata;
      for (int i = 0; i < 3; i++) begin
        off_q[i] <= reg_wdata;
      end
    end else if (wr_hit(ADDR_OFF_RED)) begin
      off_q[0] <= reg_wdata;
    end else if (wr_hit(ADDR_OFF_GREEN)) begin
      off_q[1] <= reg_wdata;
    end else if (wr_hit(ADDR_OFF_BLUE)) begin
      off_q[2] <= reg_wdata;
    end
  end

  // Upper gain fields with their broadcast.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        gup_q[i] <= GAIN_UP_RST;
      end
      gup_all_q <= BCAST_RST;
    end else if (wr_hit(ADDR_GUP_ALL)) begin
      gup_all_q <= reg_wdata;
      for (int i = 0; i < 3; i++) begin
        gup_q[i] <= reg_wdata;
      end
    end else if (wr_hit(ADDR_GUP_RED)) begin
      gup_q[0] <= reg_wdata;
    end else if (wr_hit(ADDR_GUP_GREEN)) begin
      gup_q[1] <= reg_wdata;
    end else if (wr_hit(ADDR_GUP_BLUE)) begin
      gup_q[2] <= reg_wdata;
    end
  end

  // Gain low bits with their broadcast.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        glo_q[i] <= GAIN_LO_RST;
      end
      glo_all_q <= GAIN_LO_RST;
    end else if (wr_hit(ADDR_GLO_ALL)) begin
      glo_all_q <= reg_wdata[0];
      for (int i = 0; i < 3; i++) begin
        glo_q[i] <= reg_wdata[0];
      end
    end else if (wr_hit(ADDR_GLO_RED)) begin
      glo_q[0] <= reg_wdata[0];
    end else if (wr_hit(ADDR_GLO_GREEN)) begin
      glo_q[1] <= reg_wdata[0];
    end else if (wr_hit(ADDR_GLO_BLUE)) begin
      glo_q[2] <= reg_wdata[0];
    end
  end

  // Joins the upper eight bits and the low bit into one nine-bit gain code.
  // Kept in one place so the three channels can never disagree on bit order.
  function automatic logic [8:0] gain_code(input logic [7:0] upper, input logic low);
    return {upper, low};
  endfunction

  // Codes handed to the analogue side; the DAC and amplifier maths live there.
  // Each code comes straight from its storage flops, so no glitch reaches the DACs.
  assign red_offset_code   = off_q[0];
  assign green_offset_code = off_q[1];
  assign blue_offset_code  = off_q[2];
  assign red_gain_code     = gain_code(gup_q[0], glo_q[0]);
  assign green_gain_code   = gain_code(gup_q[1], glo_q[1]);
  assign blue_gain_code    = gain_code(gup_q[2], glo_q[2]);

  // Read port: data valid only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= DATA_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_SETUP) begin
        reg_rdata <= setup_q;
      end else if (reg_addr == ADDR_MODE) begin
        reg_rdata <= mode_q;
      end else if (reg_addr == ADDR_OFF_RED) begin
        reg_rdata <= off_q[0];
      end else if (reg_addr == ADDR_OFF_GREEN) begin
        reg_rdata <= off_q[1];
      end else if (reg_addr == ADDR_OFF_BLUE) begin
        reg_rdata <= off_q[2];
      end else if (reg_addr == ADDR_OFF_ALL) begin
        reg_rdata <= off_all_q;
      end else if (reg_addr == ADDR_GLO_RED) begin
        reg_rdata <= {7'h00, glo_q[0]};
      end else if (reg_addr == ADDR_GLO_GREEN) begin
        reg_rdata <= {7'h00, glo_q[1]};
      end else if (reg_addr == ADDR_GLO_BLUE) begin
        reg_rdata <= {7'h00, glo_q[2]};
      end else if (reg_addr == ADDR_GLO_ALL) begin
        reg_rdata <= {7'h00, glo_all_q};
      end else if (reg_addr == ADDR_GUP_RED) begin
        reg_rdata <= gup_q[0];
      end else if (reg_addr == ADDR_GUP_GREEN) begin
        reg_rdata <= gup_q[1];
      end else if (reg_addr == ADDR_GUP_BLUE) begin
        reg_rdata <= gup_q[2];
      end else if (reg_addr == ADDR_GUP_ALL) begin
        reg_rdata <= gup_all_q;
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {4'h0, dly_busy_q, clamp_q, rs_s, vs_s};
      end else begin
        reg_rdata <= DATA_ZERO;
      end
    end else begin
      reg_rdata <= DATA_ZERO;
    end
  end

  // Two-flop synchronisers for the sample pins.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vs_sync_q <= 2'h0;
      rs_sync_q <= 2'h0;
    end else begin
      vs_sync_q <= {vs_sync_q[0], video_sample_pin};
      rs_sync_q <= {rs_sync_q[0], reset_sample_pin};
    end
  end
  assign vs_s = vs_sync_q[1];
  assign rs_s = rs_sync_q[1];

  assign older_mode = mode_q[BIT_OLD_MODE];
  assign detect_on  = older_mode && setup_q[BIT_DET_EN];
  // Rising edge when polarity is 1, falling when 0.
  assign edge_seen  = setup_q[BIT_POL] ? (vs_s && !vs_prev_q) : (!vs_s && vs_prev_q);

  // Edge detector and delay counter; a zero delay fires in the cycle after the edge is seen.
  // A new edge while a delay runs restarts it, trading one lost pulse for a clean period.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vs_prev_q  <= 1'b0;
      dly_cnt_q  <= DLY_ZERO;
      dly_busy_q <= 1'b0;
      pulse_q    <= 1'b0;
    end else begin
      vs_prev_q <= vs_s;
      pulse_q   <= 1'b0;
      if (!detect_on) begin
        dly_busy_q <= 1'b0;
        dly_cnt_q  <= DLY_ZERO;
      end else if (edge_seen) begin
        if (setup_q[BIT_DLY_LO +: 3] == DLY_ZERO) begin
          pulse_q <= 1'b1;
        end else begin
          dly_cnt_q  <= setup_q[BIT_DLY_LO +: 3];
          dly_busy_q <= 1'b1;
        end
      end else if (dly_busy_q) begin
        if (dly_cnt_q == DLY_ONE) begin
          pulse_q    <= 1'b1;
          dly_busy_q <= 1'b0;
        end
        dly_cnt_q <= dly_cnt_q - DLY_ONE;
      end
    end
  end

  // Sample signal to timing control: raw synchronised pin or the internal pulse.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timing_sample <= 1'b0;
    end else begin
      timing_sample <= detect_on ? pulse_q : vs_s;
    end
  end

  // Clamp switch drive; in older mode the reference timing strobe marks each pixel.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clamp_q <= 1'b0;
    end else if (!setup_q[BIT_CLAMP_EN]) begin
      clamp_q <= 1'b0;
    end else if (older_mode) begin
      clamp_q <= ref_sample_strobe;
    end else if (setup_q[BIT_CLAMP_SEL]) begin
      clamp_q <= rs_s && vs_s;
    end else begin
      clamp_q <= rs_s;
    end
  end
  assign reset_level_clamp = clamp_q;

  // Broadcast writes must reach every channel at the same edge.
  // Each property checks two channels; the extra ones below cover the third.
  a_bcast_offset: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit(ADDR_OFF_ALL) |=> (red_offset_code == $past(reg_wdata)) && (blue_offset_code == $past(reg_wdata)))
    else $error("offset broadcast not applied");
  a_bcast_gain: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit(ADDR_GUP_ALL) |=> (green_gain_code[8:1] == $past(reg_wdata)) && (red_gain_code[8:1] == $past(reg_wdata)))
    else $error("gain upper broadcast not applied");
  a_bcast_low: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit(ADDR_GLO_ALL) |=> (blue_gain_code[0] == $past(reg_wdata[0])) && (red_gain_code[0] == $past(reg_wdata[0])))
    else $error("gain low broadcast not applied");
  a_sample_pass: assert property (@(posedge clk_sys) disable iff (rst)
    !detect_on |=> timing_sample == $past(vs_s))
    else $error("sample pin not passed through");
  a_clamp_sel: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_q[BIT_CLAMP_EN] && !older_mode && setup_q[BIT_CLAMP_SEL]) |=> clamp_q == $past(rs_s && vs_s))
    else $error("combined clamp wrong");
  a_clamp_direct: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_q[BIT_CLAMP_EN] && !older_mode && !setup_q[BIT_CLAMP_SEL]) |=> clamp_q == $past(rs_s))
    else $error("direct clamp wrong");
  a_clamp_off: assert property (@(posedge clk_sys) disable iff (rst)
    !setup_q[BIT_CLAMP_EN] |=> !clamp_q)
    else $error("clamp closed while disabled");
  a_delay_one: assert property (@(posedge clk_sys) disable iff (rst)
    (detect_on && edge_seen && setup_q[BIT_DLY_LO +: 3] == DLY_ONE) ##1 (detect_on && !edge_seen) |=> pulse_q)
    else $error("delayed pulse late");
  a_no_pulse_off: assert property (@(posedge clk_sys) disable iff (rst)
    !older_mode |=> !dly_busy_q)
    else $error("detector active outside older mode");

  // Third channel of each broadcast, so a missed channel cannot hide.
  a_bcast_off_third: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit(ADDR_OFF_ALL) |=> green_offset_code == $past(reg_wdata))
    else $error("green offset missed broadcast");

  a_bcast_up_third: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit(ADDR_GUP_ALL) |=> blue_gain_code[8:1] == $past(reg_wdata))
    else $error("blue gain upper missed broadcast");

  a_bcast_low_third: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit(ADDR_GLO_ALL) |=> green_gain_code[0] == $past(reg_wdata[0]))
    else $error("green gain low missed broadcast");

  // Stored codes only move on a write; the analogue side relies on them being steady.
  a_offset_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_wr |=> $stable(red_offset_code))
    else $error("offset code moved without a write");

  a_gain_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_wr |=> $stable(red_gain_code))
    else $error("gain code moved without a write");

  // Read data stand one cycle only and are zero otherwise.
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata == DATA_ZERO)
    else $error("read data outside read cycle");

  // Sample pulse path: the internal pulse replaces the pin only when detection is on.
  a_pulse_replace: assert property (@(posedge clk_sys) disable iff (rst)
    detect_on |=> timing_sample == $past(pulse_q))
    else $error("internal pulse not forwarded");

  a_det_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (!older_mode && setup_q[BIT_DET_EN]) |=> timing_sample == $past(vs_s))
    else $error("detect bit acted outside older mode");

  a_delay_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (detect_on && edge_seen && setup_q[BIT_DLY_LO +: 3] == DLY_ZERO) |=> pulse_q)
    else $error("zero delay pulse missing");

  // With no edge and no running count there is nothing that may raise a pulse.
  a_no_stray_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    (detect_on && !edge_seen && !dly_busy_q) |=> !pulse_q)
    else $error("pulse without a selected edge");

  // Older mode clamps from the reference strobe whatever the control bit says.
  a_older_clamp: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_q[BIT_CLAMP_EN] && older_mode) |=> clamp_q == $past(ref_sample_strobe))
    else $error("older mode clamp not at strobe");

  a_sel_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_q[BIT_CLAMP_EN] && older_mode && setup_q[BIT_CLAMP_SEL]) |=> clamp_q == $past(ref_sample_strobe))
    else $error("clamp control bit acted in older mode");

  c_pulse: cover property (@(posedge clk_sys) disable iff (rst) pulse_q && timing_sample == 1'b0);
  c_bcast: cover property (@(posedge clk_sys) disable iff (rst) wr_hit(ADDR_OFF_ALL));
  c_clamp: cover property (@(posedge clk_sys) disable iff (rst) clamp_q && older_mode);
  c_long_delay: cover property (@(posedge clk_sys) disable iff (rst) dly_busy_q && dly_cnt_q == 3'h7);
  c_gain_bcast: cover property (@(posedge clk_sys) disable iff (rst) wr_hit(ADDR_GUP_ALL));

endmodule // ssc_regs

// >>> tb/ssc_scan_timing.sv
// Behavioural scanner timing controller that drives the sample pins of the bank.
// Assumes one bench sequence calls its tasks, all on clk_sys.
`timescale 1ns/1ps
module ssc_scan_timing (
  input  wire logic clk_sys,
  output logic      video_sample_pin,
  output logic      reset_sample_pin,
  output logic      ref_sample_strobe
);
  // Pins rest low until the first line starts.
  initial begin
    video_sample_pin  = 1'b0;
    reset_sample_pin  = 1'b0;
    ref_sample_strobe = 1'b0;
  end
  // Pins move just after an edge, so the sampling flops never see a race.
  task automatic drive(input logic vs, input logic rs);
    @(posedge clk_sys);
    video_sample_pin <= vs;
    reset_sample_pin <= rs;
  endtask
  // One-cycle reference strobe in the system clock domain.
  task automatic strobe_ref();
    @(posedge clk_sys);
    ref_sample_strobe <= 1'b1;
    @(posedge clk_sys);
    ref_sample_strobe <= 1'b0;
  endtask
endmodule // ssc_scan_timing

// >>> tb/test_ssc_regs.sv
// Self-checking bench for the sample-sync, clamp and gain register bank.
// Assumes the timing controller model drives the pins and the bench owns the port.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module test_ssc_regs;
  import ssc_pkg::*;
  logic       clk_sys, rst, reg_wr, reg_rd, vs, rs, rfs, ts, clamp, hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ro, go, bo, d;
  logic [8:0] rg, gg, bg;
  int         mismatches, samples_checked, n, n0, ones;
  logic [15:0] ptab [4] = '{16'h0021, 16'h002F, 16'h003F, 16'h012E};
  logic [7:0]  cset [5] = '{8'h20, 8'h20, 8'h60, 8'h60, 8'h00};
  logic [2:0]  cpin [5] = '{3'b011, 3'b100, 3'b010, 3'b111, 3'b110};
  ssc_regs ssc_regs_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_sample_pin(vs),
    .reset_sample_pin(rs), .ref_sample_strobe(rfs), .timing_sample(ts), .reset_level_clamp(clamp),
    .red_offset_code(ro), .green_offset_code(go), .blue_offset_code(bo),
    .red_gain_code(rg), .green_gain_code(gg), .blue_gain_code(bg));
  ssc_scan_timing ssc_scan_timing_i (.clk_sys(clk_sys), .video_sample_pin(vs),
    .reset_sample_pin(rs), .ref_sample_strobe(rfs));
  // Free-running 50 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Prints the counts and the verdict, then stops the run.
  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One-cycle write strobe; the slave never stalls.
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Sets mode and setup, parks the video pin and lets any stale pulse drain.
  task cfg(input logic [7:0] m, input logic [7:0] s, input logic idle);
    wr(ADDR_MODE, m);
    wr(ADDR_SETUP, s);
    ssc_scan_timing_i.drive(idle, 1'b0);
    repeat (16) @(posedge clk_sys);
  endtask
  // Cycles from the pin change until timing_sample rises, bounded.
  task lat();
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (ts !== 1'b1 && n < 24);
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    mismatches = 0; samples_checked = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK("offsets", {3{OFFSET_RST}}, {ro, go, bo})
    `CHK("gains", {3{9'h018}}, {rg, gg, bg})
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_GUP_RED + 8'(i), d);
      `CHK("gain upper reset", GAIN_UP_RST, d)
    end
    rd(ADDR_SETUP, d);
    `CHK("setup reset", SETUP_RST, d)
    rd(8'h3F, d);
    `CHK("unmapped read", DATA_ZERO, d)
    // Broadcasts must land on all channels at the same edge.
    wr(ADDR_OFF_ALL, 8'h55);
    `CHK("offset bcast", {3{8'h55}}, {ro, go, bo})
    wr(ADDR_OFF_GREEN, 8'hA3);
    `CHK("offset single", {8'h55, 8'hA3, 8'h55}, {ro, go, bo})
    wr(ADDR_GLO_ALL, 8'h01);
    `CHK("low bcast", {3{9'h019}}, {rg, gg, bg})
    wr(ADDR_GUP_ALL, 8'hA5);
    `CHK("upper bcast", {3{9'h14B}}, {rg, gg, bg})
    wr(ADDR_GUP_BLUE, 8'h3C);
    wr(ADDR_GLO_BLUE, 8'h00);
    `CHK("blue gain", 9'h078, bg)
    rd(ADDR_GUP_BLUE, d);
    `CHK("blue upper", 8'h3C, d)
    // Raw pin passes whenever detection is off or the older mode is not chosen.
    for (int i = 0; i < 4; i++) begin
      cfg(ptab[i][15:8], ptab[i][7:0], 1'b0);
      ssc_scan_timing_i.drive(1'b1, 1'b0);
      lat();
      `CHK("raw pass latency", 3, n)
    end
    // Detected pulses: one cycle wide, delayed by the field, opposite edge ignored.
    for (int p = 0; p < 2; p++) begin
      foreach (ptab[k]) begin
        if (k == 3) continue;
        d = 8'h21 | 8'(p << 4) | 8'((k == 0 ? 0 : (k == 1 ? 1 : 7)) << 1);
        cfg(8'h01, d, ~p[0]);
        ssc_scan_timing_i.drive(p[0], 1'b0);
        lat();
        if (k == 0) n0 = n;
        `CHK("pulse delay", (k == 0 ? 0 : (k == 1 ? 1 : 7)), n - n0)
        @(posedge clk_sys);
        #1 `CHK("pulse width", 1'b0, ts)
        ssc_scan_timing_i.drive(~p[0], 1'b0);
        ones = 0;
        repeat (14) begin
          @(posedge clk_sys);
          #1 ones += int'(ts === 1'b1);
        end
        `CHK("wrong edge pulses", 0, ones)
      end
    end
    // Clamp switch from the sample pins in the newer mode.
    foreach (cset[i]) begin
      cfg(8'h00, cset[i], 1'b0);
      ssc_scan_timing_i.drive(cpin[i][2], cpin[i][1]);
      repeat (4) @(posedge clk_sys);
      #1 `CHK("clamp", cpin[i][0], clamp)
    end
    // Older mode: the control bit makes no difference, the strobe sets the instant.
    cfg(8'h01, 8'h20, 1'b0);
    rd(ADDR_MODE, d);
    `CHK("mode readback", 8'h01, d)
    ssc_scan_timing_i.drive(1'b0, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1 hit = clamp;
    `CHK("older clamp idle", 1'b0, hit)
    rd(ADDR_STATUS, d);
    `CHK("status pins", 8'h02, d)
    wr(ADDR_SETUP, 8'h60);
    repeat (4) @(posedge clk_sys);
    #1 `CHK("clamp sel ignored", hit, clamp)
    ssc_scan_timing_i.drive(1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    ssc_scan_timing_i.strobe_ref();
    hit = 1'b0;
    repeat (4) begin
      #1 hit = hit | (clamp === 1'b1);
      @(posedge clk_sys);
    end
    `CHK("clamp at strobe", 1'b1, hit)
    give_verdict();
  end
endmodule // test_ssc_regs
